//--- shared/rglk_pkg.sv
// constants, types and helpers for the register-group lock and setup block
// assumes one host bus clock; every address and index here is 8/16 bits
`default_nettype none

package rglk_pkg;

    // ========================================================
    // i/o port addresses: controller (mono and colour copies), access and option
    localparam logic [15:0] CRTC_MONO_BASE  = 16'h03b4; // index, data at +1
    localparam logic [15:0] CRTC_COLOR_BASE = 16'h03d4; // index, data at +1
    localparam logic [15:0] CRTC_DATA_OFS   = 16'h0001; // data port offset
    localparam logic [15:0] ACC_PORT_ADDR   = 16'h46e8; // subsystem access
    localparam logic [15:0] OPT_PORT_ADDR   = 16'h0102; // option select

    // ========================================================
    // indexed register offsets
    localparam logic [7:0] IDX_MEM_SETUP = 8'h31; // display_memory_setup
    localparam logic [7:0] IDX_EXT_KEY   = 8'h38; // extension_group_key
    localparam logic [7:0] IDX_SYS_KEY   = 8'h39; // system_group_key
    localparam logic [7:0] IDX_MISC_ONE  = 8'h3a; // misc_control_one
    localparam logic [7:0] IDX_SYS_SETUP = 8'h40; // system_setup_control

    // ========================================================
    // key patterns: mask keeps the significant bits only
    localparam logic [7:0] EXT_KEY_MASK  = 8'hcc; // 01xx10xx
    localparam logic [7:0] EXT_KEY_VALUE = 8'h48;
    localparam logic [7:0] SYS_KEY_MASK  = 8'he0; // 101xxxxx
    localparam logic [7:0] SYS_KEY_VALUE = 8'ha0;

    // ========================================================
    // field positions
    localparam int SYS_ACCEL_BIT     = 0; // accel group access
    localparam int FONT_LOAD_BIT     = 5; // in misc_control_one
    localparam int FONT_FETCH_BIT    = 6; // in display_memory_setup
    localparam int ACC_ENABLE_BIT    = 3; // in subsystem_access_port
    localparam int ACC_SETUP_STD_BIT = 4; // setup bit, select strap high
    localparam int ACC_SETUP_ALT_BIT = 5; // setup bit, select strap low
    localparam int OPT_ENABLE_BIT    = 0; // in option_select_port

    // ========================================================
    // reset values and read answers
    localparam logic [7:0] RST_REG     = 8'h00; // every stored byte
    localparam logic [7:0] LOCKED_READ = 8'h00; // locked or unmapped
    // straps read as disabled, standard setup bit until synchronised
    localparam logic [1:0] RST_STRAPS  = 2'b11;

    // software enable sequence, gray along the usual path
    typedef enum logic [1:0]
    {
        EN_IDLE   = 2'b00,
        EN_SETUP  = 2'b01,
        EN_OPTION = 2'b11,
        EN_ON     = 2'b10
    } rglk_en_t;

    // compare only the significant bits of a key
    function automatic logic key_match
    (
        input logic [7:0] value,
        input logic [7:0] mask,
        input logic [7:0] key
    );
        key_match = ((value & mask) == key);
    endfunction : key_match

endpackage : rglk_pkg

`default_nettype wire

//--- shared/rglk_key_if.sv
// carrier between the top and the key keeper
// assumes both ends share mclk; signals are plain same-cycle levels
`default_nettype none

interface rglk_key_if;
    logic       wr_ext;   // write strobe, extension key
    logic       wr_sys;   // write strobe, system key
    logic [7:0] wdata;    // byte written
    logic [7:0] ext_key;  // stored extension key
    logic [7:0] sys_key;  // stored system key
    logic       ext_open; // extension group unlocked
    logic       sys_open; // system groups unlocked

    modport keeper (input wr_ext, wr_sys, wdata,
                    output ext_key, sys_key, ext_open, sys_open);
    modport master (output wr_ext, wr_sys, wdata,
                    input ext_key, sys_key, ext_open, sys_open);
endinterface : rglk_key_if

`default_nettype wire

//--- src/rglk_sync.sv
// two-flop synchroniser for the two strap pins
// assumes straps are slow levels from pins outside mclk
`default_nettype none

module rglk_sync
    import rglk_pkg::*;
(
    input  wire logic       mclk,  // host bus clock
    input  wire logic       nrst,  // synchronous, active low
    input  wire logic [1:0] pin,   // raw strap levels
    output logic      [1:0] level  // synchronised strap levels
);
    // ========================================================
    // state
    typedef struct packed
    {
        logic [1:0] meta;  // first stage, read by stage two only
        logic [1:0] safe;  // second stage
    } rglk_sync_t;

    rglk_sync_t q;      // registered state
    rglk_sync_t next_q; // next state

    // shift pins through both stages
    always_comb
    begin
        next_q.meta = pin;
        next_q.safe = q.meta;
    end

    // registers; reset to strap-high so no false enable follows reset
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            q <= '{meta: RST_STRAPS, safe: RST_STRAPS};
        else
            q <= next_q;
    end

    assign level = q.safe;
endmodule : rglk_sync

`default_nettype wire

//--- src/rglk_key_keeper.sv
// holds both lock keys and decodes the unlock levels
// assumes strobes come one cycle wide from the indexed port
`default_nettype none

module rglk_key_keeper
    import rglk_pkg::*;
(
    input wire logic  mclk,  // host bus clock
    input wire logic  nrst,  // synchronous, active low
    rglk_key_if.keeper kif   // strobes in, keys and levels out
);
    // ========================================================
    // state
    typedef struct packed
    {
        logic [7:0] ext_key; // last byte written to extension key
        logic [7:0] sys_key; // last byte written to system key
    } rglk_keys_t;

    rglk_keys_t q;      // registered state
    rglk_keys_t next_q; // next state

    // any write replaces the key; a bad byte therefore relocks
    always_comb
    begin
        next_q = q;
        if (kif.wr_ext)
            next_q.ext_key = kif.wdata;
        if (kif.wr_sys)
            next_q.sys_key = kif.wdata;
    end

    // zero keys match neither pattern, so both groups start locked
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            q <= '{ext_key: RST_REG, sys_key: RST_REG};
        else
            q <= next_q;
    end

    assign kif.ext_key  = q.ext_key;
    assign kif.sys_key  = q.sys_key;
    assign kif.ext_open = key_match(q.ext_key, EXT_KEY_MASK,
                                    EXT_KEY_VALUE);
    assign kif.sys_open = key_match(q.sys_key, SYS_KEY_MASK,
                                    SYS_KEY_VALUE);
endmodule : rglk_key_keeper

`default_nettype wire

//--- src/rglk_top.sv
// register-group lock and video subsystem setup, host i/o side
// assumes host i/o strobes are one cycle wide and synchronous to mclk
//
// Contract
// - extension group opens on key 01xx10xx
// - system groups open on key 101xxxxx
// - system setup bit 0 opens accel group
// - locked groups refuse both reads and writes
// - any wrong significant key bit relocks
// - enable strap low enables subsystem directly
// - enable strap high needs software enable
// - standard vga until accel group enabled
// - memory setup bit 6 selects fast fetch
`default_nettype none

module rglk_top
    import rglk_pkg::*;
(
    input  wire logic        mclk,                     // host bus clock
    input  wire logic        nrst,                     // sync reset, low
    input  wire logic [15:0] io_addr,                  // i/o address
    input  wire logic        io_wr,                    // write strobe
    input  wire logic        io_rd,                    // read strobe
    input  wire logic [7:0]  io_wdata,                 // write byte
    output logic      [7:0]  io_rdata,                 // read byte
    input  wire logic        subsystem_enable_strap_n, // strap, low on
    input  wire logic        setup_bit_select_strap,   // strap, bit 4/5
    output logic             ext_group_open,           // extension open
    output logic             sys_group_open,           // system open
    output logic             accel_group_open,         // accel open
    output logic             vga_mode_active,          // standard vga
    output logic             subsystem_enabled,        // video enabled
    output logic             font_load_active,         // font loading
    output logic             font_fetch_132            // fast font fetch
);
    // ========================================================
    // state
    typedef struct packed
    {
        logic [7:0] index;     // controller index
        logic [7:0] mem_setup; // display_memory_setup
        logic [7:0] misc_one;  // misc_control_one
        logic [7:0] sys_setup; // system_setup_control
        logic [7:0] acc_port;  // subsystem_access_port
        logic [7:0] opt_port;  // option_select_port
        rglk_en_t   en;        // software enable sequence
        logic [7:0] rdata;     // read answer
    } rglk_state_t;

    rglk_state_t q;      // registered state
    rglk_state_t next_q; // next state

    rglk_key_if  kif (); // key strobes and unlock levels

    logic [1:0]  strap_s;    // synchronised straps
    logic        strap_n_s;  // enable strap, active low
    logic        sel_s;      // setup bit select strap
    logic        idx_wr;     // index port write
    logic        dat_wr;     // data port write
    logic        dat_rd;     // data port read
    logic        acc_wr;     // access port write
    logic        acc_rd;     // access port read
    logic        opt_wr;     // option port write
    logic        opt_rd;     // option port read
    logic        setup_hit;  // written byte carries the setup bit
    logic        accel_open; // accel group unlocked
    logic [7:0]  rd_val;     // value chosen for a read

    // ========================================================
    // submodules
    // straps come from pins, so both pass two flops first
    rglk_sync u_sync
    (
        .mclk  (mclk),
        .nrst  (nrst),
        .pin   ({subsystem_enable_strap_n, setup_bit_select_strap}),
        .level (strap_s)
    );

    rglk_key_keeper u_keys
    (
        .mclk (mclk),
        .nrst (nrst),
        .kif  (kif.keeper)
    );

    assign strap_n_s = strap_s[1];
    assign sel_s     = strap_s[0];

    // ========================================================
    // address decode
    // both copies of the controller port answer the same way
    function automatic logic crtc_hit
    (
        input logic [15:0] addr,
        input logic [15:0] ofs
    );
        crtc_hit = (addr == CRTC_MONO_BASE + ofs) ||
                   (addr == CRTC_COLOR_BASE + ofs);
    endfunction : crtc_hit

    assign idx_wr = io_wr && crtc_hit(io_addr, 16'h0000);
    assign dat_wr = io_wr && crtc_hit(io_addr, CRTC_DATA_OFS);
    assign dat_rd = io_rd && crtc_hit(io_addr, CRTC_DATA_OFS);
    assign acc_wr = io_wr && (io_addr == ACC_PORT_ADDR);
    assign acc_rd = io_rd && (io_addr == ACC_PORT_ADDR);
    assign opt_wr = io_wr && (io_addr == OPT_PORT_ADDR);
    assign opt_rd = io_rd && (io_addr == OPT_PORT_ADDR);

    // the select strap decides which bit of the access port is setup
    assign setup_hit = sel_s ? io_wdata[ACC_SETUP_STD_BIT]
                             : io_wdata[ACC_SETUP_ALT_BIT];

    // accel needs the system group open as well; relocking the
    // system group therefore shuts the accel group too
    assign accel_open = kif.sys_open &&
                        q.sys_setup[SYS_ACCEL_BIT];

    // ========================================================
    // read mux; locked groups read as a fixed byte
    always_comb
    begin
        rd_val = LOCKED_READ;
        if (dat_rd)
        begin
            case (q.index)
                IDX_EXT_KEY:   rd_val = kif.ext_key;
                IDX_SYS_KEY:   rd_val = kif.sys_key;
                IDX_MEM_SETUP:
                    if (kif.ext_open)
                        rd_val = q.mem_setup;
                IDX_MISC_ONE:
                    if (kif.ext_open)
                        rd_val = q.misc_one;
                IDX_SYS_SETUP:
                    if (kif.sys_open)
                        rd_val = q.sys_setup;
                default:       rd_val = LOCKED_READ;
            endcase
        end
        else if (acc_rd)
            rd_val = q.acc_port;
        else if (opt_rd && q.en != EN_IDLE)
            rd_val = q.opt_port; // only visible outside EN_IDLE
    end

    // ========================================================
    // next state
    always_comb
    begin
        next_q     = q;
        kif.wr_ext = 1'b0;
        kif.wr_sys = 1'b0;
        kif.wdata  = io_wdata;
        // read answer held until the next read
        if (io_rd)
            next_q.rdata = rd_val;
        if (idx_wr)
            next_q.index = io_wdata;
        // indexed writes; locked groups keep their bytes
        if (dat_wr)
        begin
            case (q.index)
                IDX_EXT_KEY:   kif.wr_ext = 1'b1;
                IDX_SYS_KEY:   kif.wr_sys = 1'b1;
                IDX_MEM_SETUP:
                    if (kif.ext_open)
                        next_q.mem_setup = io_wdata;
                IDX_MISC_ONE:
                    if (kif.ext_open)
                        next_q.misc_one = io_wdata;
                IDX_SYS_SETUP:
                    if (kif.sys_open)
                        next_q.sys_setup = io_wdata;
                default:       next_q.index = q.index;
            endcase
        end
        // access port always stores; the sequence watches it
        if (acc_wr)
            next_q.acc_port = io_wdata;
        // option port only takes writes while the sequence is not in EN_IDLE
        if (opt_wr && q.en != EN_IDLE)
            next_q.opt_port = io_wdata;
        // software enable sequence
        case (q.en)
            EN_IDLE:
                if (acc_wr && setup_hit)
                    next_q.en = EN_SETUP;
            EN_SETUP:
                if (opt_wr && io_wdata[OPT_ENABLE_BIT])
                    next_q.en = EN_OPTION;
                else if (acc_wr && !setup_hit)
                    next_q.en = EN_IDLE;
            EN_OPTION:
                if (acc_wr && io_wdata[ACC_ENABLE_BIT])
                    next_q.en = EN_ON;
                else if (opt_wr && !io_wdata[OPT_ENABLE_BIT])
                    next_q.en = EN_SETUP;
                else if (acc_wr && !setup_hit)
                    next_q.en = EN_IDLE;
            EN_ON:
                if (acc_wr && !io_wdata[ACC_ENABLE_BIT])
                    next_q.en = EN_IDLE; // software disable
            default:
                next_q.en = EN_IDLE;
        endcase
    end

    // ========================================================
    // registers
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            q <= '{index: RST_REG, mem_setup: RST_REG,
                   misc_one: RST_REG, sys_setup: RST_REG,
                   acc_port: RST_REG, opt_port: RST_REG,
                   en: EN_IDLE, rdata: LOCKED_READ};
        else
            q <= next_q;
    end

    // ========================================================
    // outputs
    assign io_rdata         = q.rdata;
    assign ext_group_open   = kif.ext_open;
    assign sys_group_open   = kif.sys_open;
    assign accel_group_open = accel_open;
    assign vga_mode_active  = !accel_open;
    // strap low bypasses the software sequence entirely
    assign subsystem_enabled = !strap_n_s || (q.en == EN_ON);
    assign font_load_active = q.misc_one[FONT_LOAD_BIT];
    assign font_fetch_132   = q.mem_setup[FONT_FETCH_BIT];

    // ========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_ext_unlock;
        kif.wr_ext && key_match(io_wdata, EXT_KEY_MASK, EXT_KEY_VALUE)
        |=> ext_group_open;
    endproperty
    a_ext_unlock: assert property (p_ext_unlock)
        else $error("extension group not opened by key");

    property p_sys_unlock;
        kif.wr_sys && key_match(io_wdata, SYS_KEY_MASK, SYS_KEY_VALUE)
        |=> sys_group_open;
    endproperty
    a_sys_unlock: assert property (p_sys_unlock)
        else $error("system group not opened by key");

    property p_accel_open;
        dat_wr && q.index == IDX_SYS_SETUP && sys_group_open &&
        io_wdata[SYS_ACCEL_BIT] |=> accel_group_open && !vga_mode_active;
    endproperty
    a_accel_open: assert property (p_accel_open)
        else $error("accel group not opened by setup bit");

    property p_locked_write;
        dat_wr && q.index == IDX_MEM_SETUP && !ext_group_open
        |=> $stable(q.mem_setup);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("locked group took a write");

    property p_locked_read;
        dat_rd && q.index == IDX_SYS_SETUP && !sys_group_open
        |=> io_rdata == LOCKED_READ;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("locked group answered a read");

    property p_relock;
        kif.wr_ext && !key_match(io_wdata, EXT_KEY_MASK, EXT_KEY_VALUE)
        |=> !ext_group_open;
    endproperty
    a_relock: assert property (p_relock)
        else $error("extension group not relocked");

    property p_strap_on;
        !strap_n_s |-> subsystem_enabled;
    endproperty
    a_strap_on: assert property (p_strap_on)
        else $error("strap low but subsystem disabled");

    property p_strap_off;
        strap_n_s && q.en != EN_ON |-> !subsystem_enabled;
    endproperty
    a_strap_off: assert property (p_strap_off)
        else $error("subsystem enabled without software sequence");

    property p_setup_alt;
        q.en == EN_IDLE && acc_wr && !sel_s &&
        io_wdata[ACC_SETUP_ALT_BIT] |=> q.en == EN_SETUP;
    endproperty
    a_setup_alt: assert property (p_setup_alt)
        else $error("alternate setup bit not honoured");

    property p_fast_fetch;
        dat_wr && q.index == IDX_MEM_SETUP && ext_group_open &&
        io_wdata[FONT_FETCH_BIT] |=> font_fetch_132;
    endproperty
    a_fast_fetch: assert property (p_fast_fetch)
        else $error("fast font fetch not selected");

endmodule : rglk_top

`default_nettype wire

//--- tb/rglk_host_model.sv
// host processor model: drives the i/o strobes of the lock block
// assumes the bench calls its tasks one at a time, inputs at falling edge
`default_nettype none

module rglk_host_model
    import rglk_pkg::*;
(
    input  wire logic        mclk,     // host bus clock
    output var  logic [15:0] io_addr,  // i/o address
    output var  logic        io_wr,    // write strobe
    output var  logic        io_rd,    // read strobe
    output var  logic [7:0]  io_wdata, // write byte
    input  wire logic [7:0]  io_rdata  // read answer
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // bus idle at time zero
    initial
    begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // ========================================================
    // one access; released lines show the inverse, never a stale copy
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = wr;
        io_rd    = !wr;
        @(posedge mclk);
        @(negedge mclk);
        q        = io_rdata;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask : access

    // indexed write: index first, then data
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, CRTC_COLOR_BASE, idx, q);
        access(1'b1, CRTC_COLOR_BASE + CRTC_DATA_OFS, d, q);
    endtask : reg_write

    // indexed read through the mono copy of the port
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] q);
        access(1'b1, CRTC_MONO_BASE, idx, q);
        access(1'b0, CRTC_MONO_BASE + CRTC_DATA_OFS, 8'h00, q);
    endtask : reg_read

    // software enable: setup bit, option bit, then enable bit
    task automatic sw_enable(input int sb);
        logic [7:0] q;
        access(1'b1, ACC_PORT_ADDR, 8'h01 << sb, q);
        access(1'b1, OPT_PORT_ADDR, 8'h01, q);
        access(1'b1, ACC_PORT_ADDR, (8'h01 << sb) | 8'h08, q);
    endtask : sw_enable

    // system group is opened before the accel bit is set
    task automatic accel_unlock();
        reg_write(IDX_SYS_KEY, SYS_KEY_VALUE);
        reg_write(IDX_SYS_SETUP, 8'h01);
    endtask : accel_unlock

endmodule : rglk_host_model

`default_nettype wire

//--- tb/rglk_top_tb.sv
// self-checking bench for the lock and setup block
// assumes the host model drives the bus; straps driven here
`default_nettype none

module rglk_top_tb;
    import rglk_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, nrst, strap_n, sel;  // clock, reset, straps
    logic [15:0] io_addr;                   // host bus
    logic        io_wr, io_rd;
    logic [7:0]  io_wdata, io_rdata, q;
    logic        ext_o, sys_o, acc_o, vga_o, en_o, fl_o, ff_o;
    int          n_mismatch, checks_done;   // verdict counters

    // key table: index, byte written, expected open level
    typedef struct { logic [7:0] idx; logic [7:0] d; logic e; } rglk_row_t;
    rglk_row_t rows [10] = '{
        '{IDX_EXT_KEY, 8'h48, 1'b1}, '{IDX_EXT_KEY, 8'h7b, 1'b1},
        '{IDX_EXT_KEY, 8'h4c, 1'b0}, '{IDX_EXT_KEY, 8'h7b, 1'b1},
        '{IDX_EXT_KEY, 8'hc8, 1'b0}, '{IDX_SYS_KEY, 8'ha0, 1'b1},
        '{IDX_SYS_KEY, 8'hbf, 1'b1}, '{IDX_SYS_KEY, 8'he0, 1'b0},
        '{IDX_SYS_KEY, 8'hbf, 1'b1}, '{IDX_SYS_KEY, 8'h20, 1'b0}};

    rglk_host_model i_rglk_host_model (.mclk(mclk), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata));

    rglk_top i_rglk_top (.mclk(mclk), .nrst(nrst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .subsystem_enable_strap_n(strap_n),
        .setup_bit_select_strap(sel), .ext_group_open(ext_o),
        .sys_group_open(sys_o), .accel_group_open(acc_o),
        .vga_mode_active(vga_o), .subsystem_enabled(en_o),
        .font_load_active(fl_o), .font_fetch_132(ff_o));

    // ========================================================
    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ========================================================
    // compare helpers, one per result width
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // ========================================================
    // watchdog: the whole run needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        print_verdict();
    end

    // ========================================================
    // main sequence
    initial
    begin
        nrst = 1'b0;
        strap_n = 1'b1;
        sel = 1'b1;
        n_mismatch = 0;
        checks_done = 0;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        chk_byte(io_rdata, 8'h00);
        chk_bit(ext_o, 1'b0);
        chk_bit(sys_o, 1'b0);
        chk_bit(acc_o, 1'b0);
        chk_bit(vga_o, 1'b1);
        chk_bit(ff_o, 1'b0);
        repeat (3) @(negedge mclk);
        chk_bit(en_o, 1'b0);
        $display("test reset done");
        // key table: open level and readback of each key
        foreach (rows[i])
        begin
            i_rglk_host_model.reg_write(rows[i].idx, rows[i].d);
            chk_bit(rows[i].idx == IDX_EXT_KEY ? ext_o : sys_o,
                    rows[i].e);
            i_rglk_host_model.reg_read(rows[i].idx, q);
            chk_byte(q, rows[i].d);
        end
        $display("test key table done");
        // locked extension group refuses, then opens and relocks
        i_rglk_host_model.reg_write(IDX_MEM_SETUP, 8'h40);
        chk_bit(ff_o, 1'b0);
        i_rglk_host_model.reg_read(IDX_MEM_SETUP, q);
        chk_byte(q, 8'h00);
        i_rglk_host_model.reg_write(IDX_EXT_KEY, EXT_KEY_VALUE);
        i_rglk_host_model.reg_read(IDX_MEM_SETUP, q);
        chk_byte(q, 8'h00);
        i_rglk_host_model.reg_write(IDX_MEM_SETUP, 8'h40);
        chk_bit(ff_o, 1'b1);
        i_rglk_host_model.reg_write(IDX_MISC_ONE, 8'h20);
        chk_bit(fl_o, 1'b1);
        i_rglk_host_model.reg_write(IDX_MISC_ONE, 8'h00);
        chk_bit(fl_o, 1'b0);
        i_rglk_host_model.reg_write(IDX_EXT_KEY, 8'h00);
        i_rglk_host_model.reg_read(IDX_MEM_SETUP, q);
        chk_byte(q, 8'h00);
        $display("test extension group done");
        // accel bit refused while system group is locked
        i_rglk_host_model.reg_write(IDX_SYS_SETUP, 8'h01);
        chk_bit(acc_o, 1'b0);
        chk_bit(vga_o, 1'b1);
        i_rglk_host_model.accel_unlock();
        chk_bit(acc_o, 1'b1);
        chk_bit(vga_o, 1'b0);
        i_rglk_host_model.reg_read(IDX_SYS_SETUP, q);
        chk_byte(q, 8'h01);
        i_rglk_host_model.reg_write(IDX_SYS_KEY, 8'h00);
        chk_bit(acc_o, 1'b0);
        i_rglk_host_model.reg_read(IDX_SYS_SETUP, q);
        chk_byte(q, 8'h00);
        $display("test accel group done");
        // option port ignored while idle, then software enable
        i_rglk_host_model.access(1'b1, OPT_PORT_ADDR, 8'h01, q);
        i_rglk_host_model.access(1'b0, OPT_PORT_ADDR, 8'h00, q);
        chk_byte(q, 8'h00);
        // enter setup: the byte written while idle must not show
        i_rglk_host_model.access(1'b1, ACC_PORT_ADDR, 8'h10, q);
        i_rglk_host_model.access(1'b0, OPT_PORT_ADDR, 8'h00, q);
        chk_byte(q, 8'h00);
        i_rglk_host_model.sw_enable(ACC_SETUP_STD_BIT);
        chk_bit(en_o, 1'b1);
        i_rglk_host_model.access(1'b0, ACC_PORT_ADDR, 8'h00, q);
        chk_byte(q, 8'h18);
        i_rglk_host_model.access(1'b1, ACC_PORT_ADDR, 8'h00, q);
        chk_bit(en_o, 1'b0);
        sel = 1'b0;
        repeat (3) @(negedge mclk);
        i_rglk_host_model.sw_enable(ACC_SETUP_STD_BIT);
        chk_bit(en_o, 1'b0);
        i_rglk_host_model.access(1'b1, ACC_PORT_ADDR, 8'h00, q);
        i_rglk_host_model.sw_enable(ACC_SETUP_ALT_BIT);
        chk_bit(en_o, 1'b1);
        i_rglk_host_model.access(1'b1, ACC_PORT_ADDR, 8'h00, q);
        chk_bit(en_o, 1'b0);
        strap_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk_bit(en_o, 1'b1);
        $display("test subsystem enable done");
        // mid-run reset relocks every group and clears stored bytes
        i_rglk_host_model.reg_write(IDX_EXT_KEY, EXT_KEY_VALUE);
        chk_bit(ext_o, 1'b1);
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        chk_bit(ext_o, 1'b0);
        chk_bit(ff_o, 1'b0);
        chk_bit(acc_o, 1'b0);
        $display("test mid-run reset done");
        print_verdict();
    end

endmodule : rglk_top_tb

`default_nettype wire
